// file: dctg_pkg.sv
/*
  dctg_pkg: timing constants, command codes and state types for the
  command timing guard that spaces commands to a four-bank memory part.
  assumes one 200 MHz clock; all figures rounded up to whole cycles.
*/
package dctg_pkg;
  localparam int CLK_PS = 5000;
  // nanosecond figures kept in picoseconds so fractional values stay exact
  localparam int FOUR_ACTIVATE_WINDOW_PS = 50000;
  localparam int WRITE_RECOVERY_TIME_PS = 15000;
  localparam int WRITE_TO_READ_GAP_PS = 7500;
  localparam int READ_TO_PRECHARGE_GAP_PS = 7500;
  localparam int REFRESH_CYCLE_PS = 75000;
  localparam int SELFREFRESH_EXTRA_PS = 10000;
  localparam int PRECHARGE_PERIOD_PS = 15000;
  localparam int INPUT_SETUP_PS = 150;
  localparam int INPUT_HOLD_PS = 275;
  localparam int DEV_CLK_PS = 3000;

  function automatic int ps_to_cyc(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int FAW_CYC = ps_to_cyc(FOUR_ACTIVATE_WINDOW_PS);
  localparam int WR_CYC = ps_to_cyc(WRITE_RECOVERY_TIME_PS);
  localparam int RP_CYC = ps_to_cyc(PRECHARGE_PERIOD_PS);
  localparam int DAL_CYC = WR_CYC + RP_CYC;
  localparam int WTR_CYC = ps_to_cyc(WRITE_TO_READ_GAP_PS);
  localparam int RTP_CYC = ps_to_cyc(READ_TO_PRECHARGE_GAP_PS);
  localparam int XSNR_CYC =
    ps_to_cyc(REFRESH_CYCLE_PS + SELFREFRESH_EXTRA_PS);
  localparam int XSRD_CYC = 200;
  localparam int CCD_CYC = 2;
  localparam int XP_CYC = 2;
  localparam int XARD_CYC = 2;
  localparam int XARDS_BASE = 6;
  localparam int CKE_MIN_CYC = 3;
  localparam int ANPD_CYC = 3;
  localparam int AXPD_CYC = 8;
  localparam int CLK_HOLD_CYC =
    ps_to_cyc(INPUT_SETUP_PS + DEV_CLK_PS + INPUT_HOLD_PS);
  localparam int MAX_ACT_IN_WINDOW = 4;
  localparam int SLOW_EXIT_BIT = 12;
  localparam int CNT_W = 8;
  localparam int BANKS = 4;

  typedef enum logic [2:0] {
    DCTG_CMD_NOP = 3'h0,
    DCTG_CMD_ACT = 3'h1,
    DCTG_CMD_RD = 3'h2,
    DCTG_CMD_WR = 3'h3,
    DCTG_CMD_PRE = 3'h4,
    DCTG_CMD_WRA = 3'h5,
    DCTG_CMD_OTHER = 3'h6
  } dctg_cmd_t;

  typedef enum logic [1:0] {
    DCTG_ST_ON = 2'h0,
    DCTG_ST_PDN = 2'h1,
    DCTG_ST_SREF = 2'h2,
    DCTG_ST_CLKOFF = 2'h3
  } dctg_state_t;
endpackage

// file: dctg_cnt_if.sv
/*
  dctg_cnt_if: load and status bundle between the guard and its bank
  timer. assumes both ends run on the guard clock.
*/
`timescale 1ns/100ps
interface dctg_cnt_if;
  import dctg_pkg::*;
  logic [BANKS-1:0] ld_pre;
  logic [CNT_W-1:0] ld_val;
  logic [BANKS-1:0] pre_ok;
  modport guard (output ld_pre, output ld_val, input pre_ok);
  modport timer (input ld_pre, input ld_val, output pre_ok);
endinterface

// file: dctg_bank_timer.sv
/*
  dctg_bank_timer: one precharge down-counter per bank. a load only
  raises the count, so the longest pending wait is kept.
  assumes loads come from the guard on the same clock.
*/
`timescale 1ns/100ps
module dctg_bank_timer
  import dctg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  dctg_cnt_if.timer cnt
);
  typedef struct packed {
    logic [BANKS-1:0][CNT_W-1:0] cnt;
  } dctg_bt_t;
  dctg_bt_t st_ff;
  dctg_bt_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    for (int b = 0; b < BANKS; b++) begin
      if (st_ff.cnt[b] != '0) begin
        nxt_st.cnt[b] = st_ff.cnt[b] - 1'b1;
      end
      if (cnt.ld_pre[b] && cnt.ld_val > nxt_st.cnt[b]) begin
        nxt_st.cnt[b] = cnt.ld_val;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    for (int b = 0; b < BANKS; b++) begin
      cnt.pre_ok[b] = (st_ff.cnt[b] == '0);
    end
  end
endmodule

// file: dctg_guard.sv
/*
  dctg_guard: command timing guard placed in front of the memory pins.
  a request is passed only when every spacing rule allows it; otherwise
  it is held back by o_req_ready low. also drives clock enable, the
  termination pin and the memory clock gate. assumes the requester
  keeps its request steady until accepted, and that all inputs share
  i_clk.
*/
`timescale 1ns/100ps
module dctg_guard
  import dctg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req_valid,
  input wire logic [2:0] i_req_cmd,
  input wire logic [1:0] i_req_bank,
  input wire logic [2:0] i_req_burst_cyc,
  input wire logic i_pd_req,
  input wire logic i_sref_req,
  input wire logic i_bank_open,
  input wire logic [13:0] i_mode_word,
  input wire logic [2:0] i_additive_latency,
  input wire logic i_odt_req,
  output logic o_req_ready,
  output logic o_cmd_valid,
  output logic [2:0] o_cmd,
  output logic [1:0] o_cmd_bank,
  output logic o_cke,
  output logic o_odt,
  output logic o_mem_clk_en,
  output logic o_odt_sync_ok
);
  typedef struct packed {
    dctg_state_t pst;
    logic [FAW_CYC-1:0] act_hist;
    logic [CNT_W-1:0] ccd;
    logic [CNT_W-1:0] wtr;
    logic [CNT_W-1:0] nonrd;
    logic [CNT_W-1:0] rd;
    logic [CNT_W-1:0] cke_hold;
    logic [CNT_W-1:0] odt_stable;
    logic [CNT_W-1:0] axpd;
    logic [CNT_W-1:0] clk_hold;
    logic pd_active;
    logic cke;
    logic odt;
    logic clk_en;
    logic cmd_valid;
    logic [2:0] cmd;
    logic [1:0] bank;
  } dctg_st_t;
  dctg_st_t st_ff;
  dctg_st_t nxt_st;

  dctg_cnt_if cnt_bus ();

  dctg_bank_timer u_bank_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .cnt(cnt_bus.timer)
  );

  function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
    return (v == '0) ? v : v - 1'b1;
  endfunction

  function automatic logic [CNT_W-1:0] at_least(
    input logic [CNT_W-1:0] cur,
    input logic [CNT_W-1:0] val
  );
    return (val > cur) ? val : cur;
  endfunction

  dctg_cmd_t req;
  logic is_col;
  logic is_rd;
  logic is_wr;
  logic ok;
  logic act_full;
  logic take;
  logic slow_exit;
  logic [CNT_W-1:0] exit_rd;
  logic [CNT_W-1:0] wr_end;
  logic [3:0] act_cnt;

  always_comb begin
    req = dctg_cmd_t'(i_req_cmd);
    is_rd = (req == DCTG_CMD_RD);
    is_wr = (req == DCTG_CMD_WR) || (req == DCTG_CMD_WRA);
    is_col = is_rd || is_wr;
    slow_exit = i_mode_word[SLOW_EXIT_BIT];
    // slow exit is six less additive latency, never under one cycle
    if (CNT_W'(XARDS_BASE) > CNT_W'(i_additive_latency) + 1'b1) begin
      exit_rd = CNT_W'(XARDS_BASE) - CNT_W'(i_additive_latency);
    end else begin
      exit_rd = CNT_W'(1);
    end
    if (!slow_exit) begin
      exit_rd = CNT_W'(XARD_CYC);
    end
    wr_end = CNT_W'(i_req_burst_cyc);
    act_cnt = '0;
    for (int i = 0; i < FAW_CYC - 1; i++) begin
      act_cnt = act_cnt + 4'(st_ff.act_hist[i]);
    end
    // the window spans FAW_CYC cycles including this one
    act_full = (act_cnt >= 4'(MAX_ACT_IN_WINDOW));
    ok = (st_ff.pst == DCTG_ST_ON) && st_ff.cke;
    if (is_col && st_ff.ccd != '0) ok = 1'b0;
    if (is_rd && (st_ff.wtr != '0 || st_ff.rd != '0)) begin
      ok = 1'b0;
    end
    if (!is_rd && st_ff.nonrd != '0) ok = 1'b0;
    if (req == DCTG_CMD_ACT && act_full) ok = 1'b0;
    if (req == DCTG_CMD_PRE && !cnt_bus.pre_ok[i_req_bank]) begin
      ok = 1'b0;
    end
    if (req == DCTG_CMD_ACT && !cnt_bus.pre_ok[i_req_bank]) begin
      ok = 1'b0;
    end
    if (req == DCTG_CMD_NOP) ok = 1'b0;
    take = i_req_valid && ok;
  end

  assign o_req_ready = ok;

  always_comb begin
    nxt_st = st_ff;
    cnt_bus.ld_pre = '0;
    cnt_bus.ld_val = '0;
    nxt_st.ccd = dec(st_ff.ccd);
    nxt_st.wtr = dec(st_ff.wtr);
    nxt_st.nonrd = dec(st_ff.nonrd);
    nxt_st.rd = dec(st_ff.rd);
    nxt_st.cke_hold = dec(st_ff.cke_hold);
    nxt_st.axpd = dec(st_ff.axpd);
    nxt_st.clk_hold = dec(st_ff.clk_hold);
    nxt_st.act_hist = {st_ff.act_hist[FAW_CYC-2:0],
      take && req == DCTG_CMD_ACT};
    nxt_st.cmd_valid = take;
    if (take) begin
      nxt_st.cmd = i_req_cmd;
      nxt_st.bank = i_req_bank;
    end
    if (take && is_col) nxt_st.ccd = CNT_W'(CCD_CYC - 1);
    if (take && is_wr) begin
      nxt_st.wtr = at_least(nxt_st.wtr,
        wr_end + CNT_W'(WTR_CYC - 1));
      cnt_bus.ld_pre[i_req_bank] = 1'b1;
      if (req == DCTG_CMD_WRA) begin
        cnt_bus.ld_val = wr_end + CNT_W'(DAL_CYC - 1);
      end else begin
        cnt_bus.ld_val = wr_end + CNT_W'(WR_CYC - 1);
      end
    end
    if (take && is_rd) begin
      cnt_bus.ld_pre[i_req_bank] = 1'b1;
      cnt_bus.ld_val = CNT_W'(RTP_CYC - 1);
    end
    // termination changes only while the clock enable is high
    if (st_ff.pst == DCTG_ST_ON && i_odt_req != st_ff.odt) begin
      nxt_st.odt = i_odt_req;
      nxt_st.odt_stable = CNT_W'(ANPD_CYC);
    end else begin
      nxt_st.odt_stable = dec(st_ff.odt_stable);
    end
    unique case (st_ff.pst)
      DCTG_ST_ON: begin
        if (!take && st_ff.cke_hold == '0 && st_ff.odt_stable == '0 &&
            i_odt_req == st_ff.odt && (i_pd_req || i_sref_req)) begin
          nxt_st.cke = 1'b0;
          nxt_st.cke_hold = CNT_W'(CKE_MIN_CYC - 1);
          nxt_st.pd_active = i_bank_open;
          nxt_st.clk_hold = CNT_W'(CLK_HOLD_CYC);
          nxt_st.pst = i_sref_req ? DCTG_ST_SREF : DCTG_ST_PDN;
        end
      end
      DCTG_ST_PDN: begin
        if (!i_pd_req && st_ff.cke_hold == '0) begin
          nxt_st.cke = 1'b1;
          nxt_st.cke_hold = CNT_W'(CKE_MIN_CYC - 1);
          nxt_st.axpd = CNT_W'(AXPD_CYC);
          nxt_st.pst = DCTG_ST_ON;
          if (st_ff.pd_active) begin
            nxt_st.rd = at_least(nxt_st.rd, exit_rd);
          end else begin
            nxt_st.nonrd = at_least(nxt_st.nonrd,
              CNT_W'(XP_CYC));
          end
        end
      end
      DCTG_ST_SREF: begin
        // memory clock may stop once the hold after the drop is over
        if (st_ff.clk_hold == '0) begin
          nxt_st.clk_en = 1'b0;
          nxt_st.pst = DCTG_ST_CLKOFF;
        end
      end
      DCTG_ST_CLKOFF: begin
        if (!i_sref_req) begin
          nxt_st.clk_en = 1'b1;
          nxt_st.pst = DCTG_ST_SREF;
        end
      end
    endcase
    if (st_ff.pst == DCTG_ST_SREF && st_ff.clk_en && !i_sref_req &&
        st_ff.cke_hold == '0 && st_ff.clk_hold == '0) begin
      nxt_st.pst = DCTG_ST_ON;
      nxt_st.cke = 1'b1;
      nxt_st.clk_en = 1'b1;
      nxt_st.cke_hold = CNT_W'(CKE_MIN_CYC - 1);
      nxt_st.axpd = CNT_W'(AXPD_CYC);
      nxt_st.nonrd = CNT_W'(XSNR_CYC);
      nxt_st.rd = CNT_W'(XSRD_CYC);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_ff <= '{pst: DCTG_ST_ON, cke: 1'b1, clk_en: 1'b1,
        cmd: 3'h0, bank: 2'h0, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_cmd_valid = st_ff.cmd_valid;
  assign o_cmd = st_ff.cmd;
  assign o_cmd_bank = st_ff.bank;
  assign o_cke = st_ff.cke;
  assign o_odt = st_ff.odt;
  assign o_mem_clk_en = st_ff.clk_en;
  assign o_odt_sync_ok = st_ff.cke && (st_ff.axpd == '0);
endmodule

// file: dctg_guard_sva.sv
/*
  dctg_guard_sva: timing checks on the pins of the command guard.
  assumes it is bound to dctg_guard and sees its ports only.
*/
`timescale 1ns/100ps
module dctg_guard_sva
  import dctg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req_valid,
  input wire logic [2:0] i_req_cmd,
  input wire logic [1:0] i_req_bank,
  input wire logic o_req_ready,
  input wire logic o_cmd_valid,
  input wire logic [2:0] o_cmd,
  input wire logic [1:0] o_cmd_bank,
  input wire logic o_cke,
  input wire logic o_odt,
  input wire logic o_mem_clk_en,
  input wire logic o_odt_sync_ok
);
  logic [FAW_CYC-2:0] act_hist_ff;
  logic col;
  logic act;
  assign act = o_cmd_valid && o_cmd == DCTG_CMD_ACT;
  assign col = o_cmd_valid && (o_cmd == DCTG_CMD_RD ||
    o_cmd == DCTG_CMD_WR || o_cmd == DCTG_CMD_WRA);
  // earlier activates of the window; the current one is added below
  always_ff @(posedge i_clk) begin
    if (i_rst) act_hist_ff <= '0;
    else act_hist_ff <= {act_hist_ff[FAW_CYC-3:0], act};
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_req_answer: assert property (i_req_valid && o_req_ready &&
    i_req_cmd != 3'h0 |=> o_cmd_valid && o_cmd == $past(i_req_cmd) &&
    o_cmd_bank == $past(i_req_bank)) else $error("command not issued");
  a_no_stray: assert property (!(i_req_valid && o_req_ready) |=>
    !o_cmd_valid) else $error("command without acceptance");
  a_col_gap: assert property (
    col |=> !col) else $error("column commands too close");
  a_act_window: assert property (
    $countones(act_hist_ff) + act <= MAX_ACT_IN_WINDOW)
    else $error("too many activates in window");
  a_cke_high: assert property (
    $rose(o_cke) |-> o_cke [*3]) else $error("short clock enable high");
  a_cke_low: assert property (
    $fell(o_cke) |-> !o_cke [*3]) else $error("short clock enable low");
  a_exit_quiet: assert property (
    $rose(o_cke) |-> !o_cmd_valid [*2]) else $error("command after exit");
  a_clk_gate: assert property (
    !o_mem_clk_en |-> !o_cke) else $error("clock stopped with cke high");
  a_clk_hold: assert property (
    $fell(o_cke) |-> o_mem_clk_en) else $error("clock stopped too soon");
  a_odt_settle: assert property (
    $fell(o_cke) |-> $past(o_odt) == $past(o_odt, 2) &&
    $past(o_odt, 2) == $past(o_odt, 3)) else $error("odt not settled");
  a_odt_sync: assert property (
    $rose(o_cke) |-> !o_odt_sync_ok [*7]) else $error("odt sync too early");
endmodule
bind dctg_guard dctg_guard_sva u_sva (.i_clk(i_clk), .i_rst(i_rst),
  .i_req_valid(i_req_valid), .i_req_cmd(i_req_cmd),
  .i_req_bank(i_req_bank), .o_req_ready(o_req_ready),
  .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd), .o_cmd_bank(o_cmd_bank),
  .o_cke(o_cke), .o_odt(o_odt), .o_mem_clk_en(o_mem_clk_en),
  .o_odt_sync_ok(o_odt_sync_ok));

// file: dctg_mem_model.sv
/*
  dctg_mem_model: memory part seen from its pins; counts spacing faults.
  assumes pins come registered from the guard on the same clock.
*/
`timescale 1ns/100ps
module dctg_mem_model
  import dctg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input wire logic [2:0] i_cmd,
  input wire logic i_cke,
  input wire logic [13:0] i_mode_word,
  input wire logic [2:0] i_add_lat,
  output int o_err
);
  // strobe mode only moves the timing reference; no spacing follows
  localparam bit STROBE_DIFF = 1'b1;
  int gap, lvl, ex, slow;
  logic cke_q;
  logic col;
  assign col = i_cmd == DCTG_CMD_RD || i_cmd == DCTG_CMD_WR ||
    i_cmd == DCTG_CMD_WRA;
  always @(posedge i_clk) begin
    slow = XARDS_BASE - int'(i_add_lat);
    if (slow < 1) slow = 1;
    if (i_rst) begin
      o_err <= 0;
      gap <= 9;
      lvl <= 9;
      ex <= 999;
      cke_q <= 1'b1;
    end else begin
      gap <= gap + 1;
      lvl <= lvl + 1;
      ex <= ex + 1;
      cke_q <= i_cke;
      if (i_cke !== cke_q) begin
        lvl <= 1;
        if (lvl < CKE_MIN_CYC) o_err <= o_err + 1;
        if (i_cke) ex <= 1;
      end
      if (i_cmd_valid && col) gap <= 1;
      if (i_cmd_valid && col && gap < CCD_CYC) o_err <= o_err + 1;
      if (i_cmd_valid && ex < XP_CYC) o_err <= o_err + 1;
      if (i_cmd_valid && i_cmd == DCTG_CMD_RD &&
          i_mode_word[SLOW_EXIT_BIT] && ex < slow) begin
        o_err <= o_err + 1;
      end
    end
  end
endmodule

// file: dctg_guard_tb.sv
/*
  dctg_guard_tb: scenario bench for the command guard with a memory model.
  assumes a 200 MHz clock and the package cycle figures.
*/
`timescale 1ns/100ps
module dctg_guard_tb;
  import dctg_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_req_valid = 1'b0;
  logic [2:0] i_req_cmd = 3'h0;
  logic [1:0] i_req_bank = 2'h0;
  logic [2:0] i_req_burst_cyc = 3'h3;
  logic i_pd_req = 1'b0;
  logic i_sref_req = 1'b0;
  logic i_bank_open = 1'b0;
  logic [13:0] i_mode_word = 14'h0000;
  logic [2:0] i_additive_latency = 3'h0;
  logic i_odt_req = 1'b0;
  logic o_req_ready, o_cmd_valid, o_cke, o_odt, o_mem_clk_en, o_odt_sync_ok;
  logic [2:0] o_cmd;
  logic [1:0] o_cmd_bank;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  int mdl_err;
  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;
  dctg_guard uut (.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid),
    .i_req_cmd(i_req_cmd), .i_req_bank(i_req_bank),
    .i_req_burst_cyc(i_req_burst_cyc), .i_pd_req(i_pd_req),
    .i_sref_req(i_sref_req), .i_bank_open(i_bank_open),
    .i_mode_word(i_mode_word), .i_additive_latency(i_additive_latency),
    .i_odt_req(i_odt_req), .o_req_ready(o_req_ready),
    .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd), .o_cmd_bank(o_cmd_bank),
    .o_cke(o_cke), .o_odt(o_odt), .o_mem_clk_en(o_mem_clk_en),
    .o_odt_sync_ok(o_odt_sync_ok));
  dctg_mem_model mdl (.i_clk(i_clk), .i_rst(i_rst),
    .i_cmd_valid(o_cmd_valid), .i_cmd(o_cmd), .i_cke(o_cke),
    .i_mode_word(i_mode_word), .i_add_lat(i_additive_latency),
    .o_err(mdl_err));
  task automatic chk(input string nm, input logic [31:0] exp,
    input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  // holds the request until taken; t is the edge that took it
  task automatic req(input logic [2:0] c, input logic [1:0] b,
    output int t);
    logic ok;
    int n;
    i_req_valid <= 1'b1;
    i_req_cmd <= c;
    i_req_bank <= b;
    n = 0;
    ok = 1'b0;
    while (!ok && n < 400) begin
      #1;
      ok = o_req_ready;
      @(posedge i_clk);
      n++;
    end
    t = cyc + 1;
    chk("accept", 1, ok);
  endtask
  task idle;
    i_req_valid <= 1'b0;
    i_req_cmd <= 3'h0;
    @(posedge i_clk);
  endtask
  task automatic wait_sig(input bit sel, input logic l, output int t);
    int n;
    n = 0;
    #1;
    while ((sel ? o_mem_clk_en : o_cke) !== l && n < 400) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    t = cyc;
    chk("level", l, sel ? o_mem_clk_en : o_cke);
    @(posedge i_clk);
  endtask
  task t_reset;
    chk("cke", 1, o_cke);
    chk("clk_en", 1, o_mem_clk_en);
    chk("odt", 0, o_odt);
    chk("cmd_valid", 0, o_cmd_valid);
    chk("sync_ok", 1, o_odt_sync_ok);
    $display("test reset done");
  endtask
  task t_faw;
    int t0, t1, k;
    req(DCTG_CMD_ACT, 2'h0, t0);
    for (k = 1; k < 5; k++) req(DCTG_CMD_ACT, k[1:0], t1);
    idle;
    chk("act_window", FAW_CYC, t1 - t0);
    $display("test activate window done");
  endtask
  task t_column;
    int a, b;
    req(DCTG_CMD_RD, 2'h1, a);
    req(DCTG_CMD_RD, 2'h1, b);
    chk("col_gap", CCD_CYC, b - a);
    req(DCTG_CMD_WR, 2'h1, a);
    req(DCTG_CMD_RD, 2'h1, b);
    chk("wr_rd", 3 + WTR_CYC, b - a);
    req(DCTG_CMD_PRE, 2'h1, a);
    chk("rd_pre", RTP_CYC, a - b);
    req(DCTG_CMD_WR, 2'h2, a);
    req(DCTG_CMD_PRE, 2'h2, b);
    chk("wr_pre", 3 + WR_CYC, b - a);
    req(DCTG_CMD_WRA, 2'h3, a);
    req(DCTG_CMD_ACT, 2'h3, b);
    idle;
    chk("wra_act", 3 + DAL_CYC, b - a);
    $display("test column spacing done");
  endtask
  task t_pd;
    int opn [5] = '{1, 1, 1, 1, 0};
    int slw [5] = '{0, 1, 1, 1, 0};
    int lat [5] = '{0, 0, 2, 5, 0};
    int k, td, tf, tr, t, e;
    for (k = 0; k < 5; k++) begin
      i_bank_open <= opn[k][0];
      i_additive_latency <= lat[k][2:0];
      i_mode_word <= 14'(slw[k]) << SLOW_EXIT_BIT;
      i_odt_req <= ~i_odt_req;
      i_pd_req <= 1'b1;
      td = cyc + 1;
      wait_sig(1'b0, 1'b0, tf);
      chk("odt_settle", 1, tf - td >= ANPD_CYC);
      chk("odt", i_odt_req, o_odt);
      i_pd_req <= 1'b0;
      wait_sig(1'b0, 1'b1, tr);
      chk("cke_low", 1, tr - tf >= CKE_MIN_CYC);
      e = opn[k] ? XARD_CYC : XP_CYC;
      if (slw[k] != 0) begin
        e = (XARDS_BASE - lat[k] < 1) ? 1 : XARDS_BASE - lat[k];
      end
      req(opn[k] ? DCTG_CMD_RD : DCTG_CMD_ACT, 2'h1, t);
      idle;
      chk("exit_wait", 1, t - tr >= e);
    end
    $display("test power down done");
  endtask
  task t_sref;
    int tf, tc, tr, t;
    i_sref_req <= 1'b1;
    wait_sig(1'b0, 1'b0, tf);
    wait_sig(1'b1, 1'b0, tc);
    chk("clk_hold", 1, tc - tf >= CLK_HOLD_CYC);
    repeat (4) @(posedge i_clk);
    i_sref_req <= 1'b0;
    wait_sig(1'b0, 1'b1, tr);
    req(DCTG_CMD_ACT, 2'h2, t);
    chk("sref_nonread", 1, t - tr >= XSNR_CYC);
    req(DCTG_CMD_RD, 2'h2, t);
    idle;
    chk("sref_read", 1, t - tr >= XSRD_CYC);
    chk("model_errors", 0, mdl_err);
    $display("test self refresh done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    $display("watchdog expired");
    miscompares++;
    final_report;
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    t_reset;
    @(posedge i_clk);
    t_faw;
    t_column;
    t_pd;
    t_sref;
    final_report;
  end
endmodule
